/* File: design/ebh_consts.vh */
// Constants for the external bus hold arbiter.
// Assumes inclusion by the arbiter module only.
`ifndef EBH_CONSTS_VH
`define EBH_CONSTS_VH
`define EBH_ACK_MIN_CLK 3'h2
`define EBH_ST_IDLE 3'h0
`define EBH_ST_ENTRY 3'h1
`define EBH_ST_HOLD 3'h2
`define EBH_ST_ACKOFF 3'h3
`define EBH_ST_PRECHG 3'h4
`define EBH_GNT_NONE 3'h0
`define EBH_GNT_REFRESH 3'h1
`define EBH_GNT_DMA 3'h2
`define EBH_GNT_OPERAND 3'h3
`define EBH_GNT_FETCH 3'h4
`define EBH_GNT_HOLD 3'h5
`define EBH_WIDTH_8 2'h0
`define EBH_WIDTH_16 2'h1
`define EBH_WIDTH_32 2'h2
`define EBH_SIZE_BYTE 2'h0
`define EBH_SIZE_HALF 2'h1
`define EBH_SIZE_WORD 2'h2
`endif

/* File: design/ebh_hold_arbiter.v */
// External bus hold arbiter: hold request/acknowledge, bus float, priority.
// Assumes the bus controller reports split-access part numbers and idles.
`timescale 1ns/1ps
`default_nettype none
`include "ebh_consts.vh"

// Contract
// - Hold works only when both control pins are set to control function.
// - Sampled low request floats address/data bus and all strobes.
// - Request back high makes the device drive bus and strobes again.
// - While held, internal work goes on; only external accesses stall.
// - Acknowledge goes low no earlier than two clocks after request low.
// - 32-bit bus: no hold inside locked split word or odd halfword parts.
// - 16-bit bus: no hold inside locked split word or odd halfword parts.
// - 8-bit bus: no hold between any parts of word or halfword transfer.
// - No hold between read and write of a bit manipulation sequence.
// - After hold outside HALT the device issues all-bank precharge before own SDRAM use.
// - Reset ignores the hold request; no hold entered.
// - Request held through reset is acknowledged right after release.
// - In STOP or IDLE no new hold is entered; one already entered stays acknowledged until the mode ends.
// - In HALT acknowledge follows request without waiting for cycle end.
// - In HALT request release drops acknowledge and returns to HALT.
// - An idle state is always inserted at hold entry.
// - Floated set includes byte strobes, write enable, io and SDRAM strobes.
// - Hold beats refresh, DMA, operand, fetch, in that order.
module ebh_hold_arbiter (
  input wire clk,
  input wire reset,
  input wire hold_request_n,
  output reg hold_ack_n,
  input wire port_cm_pin_two,
  input wire port_cm_pin_three,
  input wire stopIdleMode,
  input wire haltMode,
  input wire cycleBoundary,
  input wire [1:0] busWidth,
  input wire [1:0] accessSize,
  input wire [1:0] accessAddrLow,
  input wire [1:0] accessPart,
  input wire rmwLock,
  input wire sdramPresent,
  input wire refreshReq,
  input wire dmaReq,
  input wire operandReq,
  input wire fetchReq,
  input wire externalAccessReq,
  output reg [2:0] busGrant,
  output reg externalStall,
  output reg busDriveEn,
  output reg strobeDriveEn,
  output reg idle_cycle_state,
  output reg prechargeAllCmd,
  output reg holdActive
);
  localparam [2:0] ACK_MIN = `EBH_ACK_MIN_CLK;

  reg reqSync1;
  reg reqSync2;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] reqAge;
  reg busLocked;
  reg holdEnable;
  reg reqActive;

  // Two-flop synchroniser on the pin; only reqSync2 is read
  // Runs through reset so a request held across it is seen at release
  always @(posedge clk) begin
    reqSync1 <= hold_request_n;
    reqSync2 <= reqSync1;
  end

  // Lock windows between parts of a split access
  always @* begin
    busLocked = 1'b0;
    case (busWidth)
      `EBH_WIDTH_32: begin
        if (accessSize == `EBH_SIZE_WORD) begin
          if (accessAddrLow[0]) begin
            busLocked = (accessPart == 2'h1) || (accessPart == 2'h2);
          end else if (accessAddrLow == 2'h2) begin
            busLocked = (accessPart == 2'h1);
          end
        end else if (accessSize == `EBH_SIZE_HALF && accessAddrLow[0]) begin
          busLocked = (accessPart == 2'h1);
        end
      end
      `EBH_WIDTH_16: begin
        if (accessSize == `EBH_SIZE_WORD) begin
          busLocked = (accessPart == 2'h1) || (accessAddrLow[0] && accessPart == 2'h2);
        end else if (accessSize == `EBH_SIZE_HALF && accessAddrLow[0]) begin
          busLocked = (accessPart == 2'h1);
        end
      end
      default: begin
        if (accessSize == `EBH_SIZE_WORD) begin
          busLocked = (accessPart != 2'h0);
        end else if (accessSize == `EBH_SIZE_HALF) begin
          busLocked = (accessPart == 2'h1);
        end
      end
    endcase
    if (rmwLock) begin
      busLocked = 1'b1;
    end
  end

  always @* begin
    holdEnable = port_cm_pin_two && port_cm_pin_three;
    reqActive = holdEnable && !reqSync2 && !stopIdleMode;
  end

  // Request age counter; keeps counting in reset, state stays idle there
  always @(posedge clk) begin
    if (!reqActive) begin
      reqAge <= 3'h0;
    end else if (reqAge != 3'h7) begin
      reqAge <= reqAge + 3'h1;
    end
  end

  always @* begin
    next_state = state;
    case (state)
      `EBH_ST_IDLE: begin
        // HALT needs no cycle boundary; otherwise wait for an unlocked boundary
        if (reqActive && reqAge >= ACK_MIN - 3'h1 && !busLocked && (haltMode || cycleBoundary)) begin
          next_state = `EBH_ST_ENTRY;
        end
      end
      `EBH_ST_ENTRY: begin
        next_state = `EBH_ST_HOLD;
      end
      `EBH_ST_HOLD: begin
        if (!reqActive && !stopIdleMode) begin
          next_state = `EBH_ST_ACKOFF;
        end
      end
      `EBH_ST_ACKOFF: begin
        next_state = (sdramPresent && !haltMode) ? `EBH_ST_PRECHG : `EBH_ST_IDLE;
      end
      `EBH_ST_PRECHG: begin
        next_state = `EBH_ST_IDLE;
      end
      default: begin
        next_state = `EBH_ST_IDLE;
      end
    endcase
  end

  // Request held across reset is seen at once after release
  always @(posedge clk) begin
    if (reset) begin
      state <= `EBH_ST_IDLE;
      hold_ack_n <= 1'b1;
      busDriveEn <= 1'b0;
      strobeDriveEn <= 1'b0;
      idle_cycle_state <= 1'b0;
      prechargeAllCmd <= 1'b0;
      holdActive <= 1'b0;
      externalStall <= 1'b0;
      busGrant <= `EBH_GNT_NONE;
    end else begin
      state <= next_state;
      // Float bus and every strobe from entry until one clock after ack is released
      busDriveEn <= (next_state == `EBH_ST_IDLE) || (next_state == `EBH_ST_PRECHG);
      strobeDriveEn <= (next_state == `EBH_ST_IDLE) || (next_state == `EBH_ST_PRECHG);
      idle_cycle_state <= (next_state == `EBH_ST_ENTRY);
      hold_ack_n <= !(next_state == `EBH_ST_HOLD);
      holdActive <= (next_state != `EBH_ST_IDLE);
      prechargeAllCmd <= (next_state == `EBH_ST_PRECHG);
      // Only external traffic waits; internal work keeps running
      externalStall <= externalAccessReq && (next_state != `EBH_ST_IDLE);
      if (next_state != `EBH_ST_IDLE) begin
        busGrant <= `EBH_GNT_HOLD;
      end else if (refreshReq) begin
        busGrant <= `EBH_GNT_REFRESH;
      end else if (dmaReq) begin
        busGrant <= `EBH_GNT_DMA;
      end else if (operandReq) begin
        busGrant <= `EBH_GNT_OPERAND;
      end else if (fetchReq) begin
        busGrant <= `EBH_GNT_FETCH;
      end else begin
        busGrant <= `EBH_GNT_NONE;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/ebh_hold_arbiter_properties.sv */
// Port checker for the hold arbiter.
// Assumes a bind from the bench top.
`timescale 1ns/1ps
`default_nettype none
module ebh_hold_arbiter_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic hold_request_n,
  input wire logic hold_ack_n,
  input wire logic port_cm_pin_two,
  input wire logic port_cm_pin_three,
  input wire logic stopIdleMode,
  input wire logic haltMode,
  input wire logic sdramPresent,
  input wire logic [2:0] busGrant,
  input wire logic busDriveEn,
  input wire logic strobeDriveEn,
  input wire logic idle_cycle_state,
  input wire logic prechargeAllCmd
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_ACK_MIN: assert property ($fell(hold_ack_n) |-> !$past(hold_request_n) && !$past(hold_request_n, 2))
    else $error("ack too soon");
  AST_FLOAT: assert property (!hold_ack_n |-> !busDriveEn && !strobeDriveEn)
    else $error("driving while held");
  AST_GRANT: assert property (!hold_ack_n |-> busGrant == 3'h5)
    else $error("hold not top grant");
  AST_IDLE: assert property ($fell(strobeDriveEn) |-> idle_cycle_state)
    else $error("no idle at entry");
  // Six cycles lets a hold decided just before the mode change finish
  AST_STOP: assert property (stopIdleMode [*6] ##0 hold_ack_n |=> hold_ack_n)
    else $error("ack in stop");
  AST_PINS: assert property (!(port_cm_pin_two && port_cm_pin_three) [*6] ##0 hold_ack_n |=> hold_ack_n)
    else $error("ack with port pins");
  AST_PRECHG: assert property ($rose(hold_ack_n) && sdramPresent && !haltMode |=> prechargeAllCmd)
    else $error("no precharge");
  AST_REDRIVE: assert property ($rose(hold_ack_n) |=> busDriveEn && strobeDriveEn)
    else $error("no redrive");
endmodule
`default_nettype wire

/* File: test/ebh_other_master.sv */
// Second bus master: drives the hold request pin.
// Assumes the bench raises want while it needs the bus.
`timescale 1ns/1ps
`default_nettype none
module ebh_other_master (
  input wire logic clk,
  input wire logic want,
  output logic hold_request_n
);
  initial hold_request_n = 1'b1;
  // It never issues SDRAM commands of its own
  always @(posedge clk) hold_request_n <= #1 !want;
endmodule
`default_nettype wire

/* File: test/ebh_hold_arbiter_tb_top.sv */
// Bench for the hold arbiter: entry, refusals, halt, reset.
// Assumes the arbiter, its checker and the other master model.
`timescale 1ns/1ps
`default_nettype none
module ebh_hold_arbiter_tb_top;
  logic clk = 0, reset = 1, want = 0, stopIdleMode = 0, haltMode = 0, cycleBoundary = 1, rmwLock = 0;
  logic port_cm_pin_two = 1, port_cm_pin_three = 1, sdramPresent = 1, refreshReq = 1;
  logic [1:0] busWidth = 2'h2, accessSize = 2'h0, accessPart = 2'h0;
  logic hold_request_n, hold_ack_n, busDriveEn, strobeDriveEn, idle_cycle_state, prechargeAllCmd;
  logic [2:0] busGrant;
  logic extReq = 0, externalStall, holdActive;
  logic [8:0] tbl [5] = '{9'h1a0, 9'h020, 9'h0e0, 9'h089, 9'h099};
  int num_errors = 0, comparisons = 0, n;
  always #25 clk = ~clk;
  ebh_other_master peer (.clk, .want, .hold_request_n);
  ebh_hold_arbiter dut (.clk, .reset, .hold_request_n, .hold_ack_n, .port_cm_pin_two, .port_cm_pin_three,
    .stopIdleMode, .haltMode, .cycleBoundary, .busWidth, .accessSize, .accessAddrLow(2'h0), .accessPart,
    .rmwLock, .sdramPresent, .refreshReq, .dmaReq(1'b0), .operandReq(1'b0), .fetchReq(1'b0),
    .externalAccessReq(extReq), .busGrant, .externalStall, .busDriveEn, .strobeDriveEn, .idle_cycle_state,
    .prechargeAllCmd, .holdActive);
  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic waitAck(input logic v);
    n = 0;
    while (hold_ack_n !== v && n < 40) begin
      @(posedge clk) #1;
      n++;
    end
    check(n < 40, "ack wait timed out");
    if (n == 40) give_verdict();
  endtask
  task automatic basic;
    @(posedge clk) #1;
    check(busGrant === 3'h1, "refresh not granted");
    extReq = 1;
    want = 1;
    waitAck(0);
    check(n >= 3, "ack too early");
    check(externalStall === 1'b1 && holdActive === 1'b1, "no stall in hold");
    extReq = 0;
    check(busDriveEn === 1'b0 && strobeDriveEn === 1'b0, "bus not floated");
    check(busGrant === 3'h5, "hold lost to refresh");
    want = 0;
    waitAck(1);
    @(posedge clk) #1;
    check(busDriveEn === 1'b1 && strobeDriveEn === 1'b1 && prechargeAllCmd === 1'b1, "redrive");
    $display("basic done");
  endtask
  task automatic refusals;
    for (int k = 0; k < 5; k++) begin
      {stopIdleMode, port_cm_pin_two, rmwLock, busWidth, accessSize, accessPart} = tbl[k];
      want = 1;
      repeat (12) @(posedge clk) #1;
      check(hold_ack_n === 1'b1, "refused hold acked");
      want = 0;
      repeat (4) @(posedge clk) #1;
      {stopIdleMode, port_cm_pin_two, rmwLock, busWidth, accessSize, accessPart} = 9'h0a0;
    end
    $display("refusals done");
  endtask
  task automatic haltCase;
    haltMode = 1;
    cycleBoundary = 0;
    want = 1;
    waitAck(0);
    want = 0;
    waitAck(1);
    @(posedge clk) #1;
    check(busDriveEn === 1'b1 && prechargeAllCmd === 1'b0, "halt exit");
    haltMode = 0;
    cycleBoundary = 1;
    $display("halt done");
  endtask
  task automatic resetHeld;
    reset = 1;
    want = 1;
    repeat (8) @(posedge clk) #1 check(hold_ack_n === 1'b1, "ack in reset");
    reset = 0;
    waitAck(0);
    check(n <= 2, "reset-held ack late");
    want = 0;
    waitAck(1);
    $display("reset done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 reset = 0;
    basic();
    refusals();
    haltCase();
    resetHeld();
    give_verdict();
  end
endmodule
bind ebh_hold_arbiter ebh_hold_arbiter_properties chk (.clk, .reset, .hold_request_n, .hold_ack_n,
  .port_cm_pin_two, .port_cm_pin_three, .stopIdleMode, .haltMode, .sdramPresent, .busGrant, .busDriveEn,
  .strobeDriveEn, .idle_cycle_state, .prechargeAllCmd);
`default_nettype wire
